// ===== shared/eim_pkg.sv
// Constants for the mode control of external interrupt sources 10 and 11.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package eim_pkg;

    // Printed register index; the byte address is four times its low bits.
    localparam logic [31:0] MODE_REG_IDX = 32'hFFFF_E00A;
    localparam logic [7:0]  MODE_ADDR    = 8'h28;
    localparam logic [7:0]  STAT_ADDR    = 8'h2C;
    localparam logic [7:0]  MASK_ADDR    = 8'h30;

    // Each source owns one byte of the mode word.
    localparam int SRC10_LSB = 16;
    localparam int SRC11_LSB = 24;
    localparam int FLD_W     = 6;
    localparam int LVL_LSB   = 0;
    localparam int TRIG_BIT  = 3;
    localparam int SENSE_LSB = 4;

    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_HIGH = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    localparam logic [5:0] MODE_RST = 6'h00;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== design/eim_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the pins are plain levels with no timing relation to aclk.
`timescale 1ns/1ps
module eim_sync #(
    parameter int W = 2
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] pin_async,
    output logic      [W-1:0] pin_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_async;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;
endmodule

// ===== design/eim_src_detect.sv
// Sensitivity decode and routing of one external interrupt source.
// Assumes a synchronised pin level and static mode fields from the register.
`timescale 1ns/1ps
module eim_src_detect
    import eim_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [1:0] sense,
    input  wire logic       trig_sel,
    input  wire logic [2:0] level,
    input  wire logic       pin_sync,
    output logic            hit,
    output logic            cpu_req,
    output logic [3:0]      dma_req
);
    logic prev_q;
    wire  rise_w = pin_sync & ~prev_q;
    wire  fall_w = ~pin_sync & prev_q;
    // Codes 4 to 7 are not channels, so they never start a transfer.
    wire  chan_ok_w = ~level[2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= pin_sync;
        end
    end

    always_comb begin
        unique case (sense) // see [R1]
            SENSE_LOW:  hit = ~pin_sync;
            SENSE_HIGH: hit = pin_sync;
            SENSE_FALL: hit = fall_w;
            SENSE_RISE: hit = rise_w;
        endcase
    end

    assign cpu_req = hit & ~trig_sel & (level != 3'h0); // see [R2] [R3]
    assign dma_req = (hit & trig_sel & chan_ok_w) ? (4'h1 << level[1:0]) : 4'h0; // see [R3] [R4]
endmodule

// ===== design/eim_ctrl.sv
// Mode control of external interrupt sources 10 and 11 behind AXI4-Lite.
// Assumes a single aclk domain; pins arrive asynchronously and are synchronised.
//
// Functional notes
// [R1] Each source decodes its sense field: 00 low level, 01 high level, 10 falling edge, 11 rising edge.
// [R2] With trigger-select 0 the 3-bit field is a priority, 000 disabled and 001 to 111 levels 1 to 7.
// [R3] With trigger-select 1 the detected event starts a transfer instead of a CPU interrupt; the code still sets its status bit, so irq fires if unmasked.
// [R4] In trigger mode the 3-bit field codes 000 to 011 pick transfer channels 0 to 3.
// [R5] Software must not write codes 100 to 111 while a source is in trigger mode.
// [R6] Source 10 comes from pin five with bits 16 to 23, source 11 from pin six with bits 24 to 31.
// [R7] Reset clears all sense, trigger-select and level fields of both sources to zero.
`timescale 1ns/1ps
module eim_ctrl
    import eim_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          ext_irq_pin_five,
    input  wire logic          ext_irq_pin_six,
    output logic               src10_cpu_req,
    output logic [2:0]         src10_cpu_prio,
    output logic               src11_cpu_req,
    output logic [2:0]         src11_cpu_prio,
    output logic [3:0]         dma_start,
    output logic               irq
);
    import eim_pkg::*;

    logic [FLD_W-1:0] mode10_q;
    logic [FLD_W-1:0] mode11_q;
    logic [1:0]       stat_q;
    logic [1:0]       mask_q;
    logic             aw_full_q;
    logic [AW-1:0]    aw_addr_q;
    logic             w_full_q;
    logic [31:0]      w_data_q;
    logic [3:0]       w_strb_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;
    logic             cpu10_q;
    logic             cpu11_q;
    logic [3:0]       dma_q;
    logic             irq_q;

    logic [1:0] pin_sync;
    logic       hit10;
    logic       hit11;
    logic       cpu10;
    logic       cpu11;
    logic [3:0] dma10;
    logic [3:0] dma11;

    eim_sync #(
        .W (2)
    ) u_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_async ({ext_irq_pin_six, ext_irq_pin_five}),
        .pin_sync  (pin_sync)
    );

    // Source 10 listens to pin five, source 11 to pin six; see [R6]
    eim_src_detect u_src10 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .sense    (mode10_q[SENSE_LSB +: 2]),
        .trig_sel (mode10_q[TRIG_BIT]),
        .level    (mode10_q[LVL_LSB +: 3]),
        .pin_sync (pin_sync[0]),
        .hit      (hit10),
        .cpu_req  (cpu10),
        .dma_req  (dma10)
    );

    eim_src_detect u_src11 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .sense    (mode11_q[SENSE_LSB +: 2]),
        .trig_sel (mode11_q[TRIG_BIT]),
        .level    (mode11_q[LVL_LSB +: 3]),
        .pin_sync (pin_sync[1]),
        .hit      (hit11),
        .cpu_req  (cpu11),
        .dma_req  (dma11)
    );

    // Write channel: address and data are held separately, so either may come first.
    wire take_aw  = s_axi_awvalid & ~aw_full_q;
    wire take_w   = s_axi_wvalid & ~w_full_q;
    wire do_write = aw_full_q & w_full_q & ~bvalid_q;
    wire wr_mode  = aw_addr_q[AW-1:2] == MODE_ADDR[AW-1:2];
    wire wr_stat  = aw_addr_q[AW-1:2] == STAT_ADDR[AW-1:2];
    wire wr_mask  = aw_addr_q[AW-1:2] == MASK_ADDR[AW-1:2];
    wire wr_hit   = wr_mode | wr_stat | wr_mask;
    // Bits 22, 23, 30 and 31 are reserved and are not stored; see [R6]
    wire wr_m10   = do_write & wr_mode & w_strb_q[2];
    wire wr_m11   = do_write & wr_mode & w_strb_q[3];
    wire wr_st    = do_write & wr_stat & w_strb_q[0];
    wire wr_mk    = do_write & wr_mask & w_strb_q[0];

    // Events only count when the source is routed somewhere; see [R2] and [R3]
    wire [1:0] ev_w  = {cpu11 | (|dma11), cpu10 | (|dma10)};
    // A new event wins over a write-one clear in the same cycle.
    wire [1:0] clr_w = wr_st ? w_data_q[1:0] : 2'h0;
    wire [1:0] stat_d = (stat_q & ~clr_w) | ev_w;
    // The interrupt uses the mask as written at the same edge, so a mask change never lags a cycle.
    wire [1:0] mask_d = wr_mk ? w_data_q[1:0] : mask_q;

    wire take_ar = s_axi_arvalid & ~rvalid_q;
    wire rd_mode = s_axi_araddr[AW-1:2] == MODE_ADDR[AW-1:2];
    wire rd_stat = s_axi_araddr[AW-1:2] == STAT_ADDR[AW-1:2];
    wire rd_mask = s_axi_araddr[AW-1:2] == MASK_ADDR[AW-1:2];
    wire rd_hit  = rd_mode | rd_stat | rd_mask;
    wire [31:0] mode_word = {2'h0, mode11_q, 2'h0, mode10_q, 16'h0000};
    wire [31:0] rd_mux = rd_mode ? mode_word :
                         rd_stat ? {30'h0, stat_q} :
                         rd_mask ? {30'h0, mask_q} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (take_aw) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (take_w) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Software is trusted not to set channel codes 4 to 7 in trigger mode; see [R5]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode10_q <= MODE_RST; // see [R7]
            mode11_q <= MODE_RST; // see [R7]
        end else begin
            if (wr_m10) begin
                mode10_q <= w_data_q[SRC10_LSB +: FLD_W]; // see [R6]
            end
            if (wr_m11) begin
                mode11_q <= w_data_q[SRC11_LSB +: FLD_W]; // see [R6]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= STAT_RST;
            mask_q <= MASK_RST;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (take_ar) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu10_q <= 1'b0;
            cpu11_q <= 1'b0;
            dma_q   <= 4'h0;
            irq_q   <= 1'b0;
        end else begin
            cpu10_q <= cpu10; // see [R1]
            cpu11_q <= cpu11; // see [R1]
            dma_q   <= dma10 | dma11; // see [R4]
            irq_q   <= |(stat_d & mask_d);
        end
    end

    assign s_axi_awready  = ~aw_full_q;
    assign s_axi_wready   = ~w_full_q;
    assign s_axi_bvalid   = bvalid_q;
    assign s_axi_bresp    = bresp_q;
    assign s_axi_arready  = ~rvalid_q;
    assign s_axi_rvalid   = rvalid_q;
    assign s_axi_rdata    = rdata_q;
    assign s_axi_rresp    = rresp_q;
    assign src10_cpu_req  = cpu10_q;
    assign src11_cpu_req  = cpu11_q;
    assign src10_cpu_prio = mode10_q[LVL_LSB +: 3]; // see [R2]
    assign src11_cpu_prio = mode11_q[LVL_LSB +: 3]; // see [R2]
    assign dma_start      = dma_q;
    assign irq            = irq_q;

    AST_RESET_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // see [R7]
        $rose(aresetn) |-> (mode10_q == 6'h00 && mode11_q == 6'h00 && !src10_cpu_req))
        else $error("Mode fields not cleared by reset.");

    AST_LEVEL_SENSE: assert property (@(posedge aclk) disable iff (!aresetn) // see [R1]
        (mode10_q[3:0] != 4'h0 && mode10_q[3] == 1'b0 &&
         ((mode10_q[5:4] == 2'h0 && !pin_sync[0]) || (mode10_q[5:4] == 2'h1 && pin_sync[0])))
        |=> src10_cpu_req)
        else $error("Level sensitive source 10 did not request.");

    AST_EDGE_SENSE: assert property (@(posedge aclk) disable iff (!aresetn) // see [R1]
        (mode11_q[5:4] == 2'h3 && $stable(mode11_q) && !pin_sync[1]) ##1 pin_sync[1]
        |-> (hit11 ##1 !hit11 || !pin_sync[1]))
        else $error("Rising edge on source 11 not seen exactly once.");

    AST_DISABLED: assert property (@(posedge aclk) disable iff (!aresetn) // see [R2]
        (mode10_q[3:0] == 4'h0) [*2] |-> !src10_cpu_req)
        else $error("Disabled source 10 raised a CPU request.");

    AST_TRIG_NO_CPU: assert property (@(posedge aclk) disable iff (!aresetn) // see [R3]
        (mode11_q[3] && $past(mode11_q[3])) |-> !src11_cpu_req)
        else $error("Source 11 in trigger mode raised a CPU request.");

    AST_DMA_CHANNEL: assert property (@(posedge aclk) disable iff (!aresetn) // see [R4]
        (hit10 && mode10_q[3] && !mode10_q[2]) |=> dma_start[$past(mode10_q[1:0])])
        else $error("Transfer start not on the selected channel.");

    AST_SRC11_FIELD: assert property (@(posedge aclk) disable iff (!aresetn) // see [R6]
        wr_m11 |=> (mode11_q == $past(w_data_q[29:24])))
        else $error("Source 11 field not taken from bits 24 to 29.");

    AST_IRQ_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == ((stat_q & mask_q) != 2'h0))
        else $error("Interrupt does not follow the unmasked status bits.");
endmodule

// ===== dv/eim_far_end.sv
// Far-side model: the two external interrupt pins and the transfer controller.
// Assumes it shares aclk with the block and changes pins only just after a rising edge.
`timescale 1ns/1ps
module eim_far_end (
    input  wire logic       aclk,
    input  wire logic [3:0] dma_start,
    input  wire logic       src10_cpu_req,
    input  wire logic       src11_cpu_req,
    output logic            ext_irq_pin_five,
    output logic            ext_irq_pin_six
);
    logic [5:0] prev_q;
    int         dma_cnt[4];
    int         cpu10_cnt;
    int         cpu11_cnt;

    initial begin
        ext_irq_pin_five = 1'b0;
        ext_irq_pin_six  = 1'b0;
        prev_q           = 6'h00;
    end

    // A held level counts once, as a channel latches only the rising start.
    always @(posedge aclk) begin
        for (int n = 0; n < 4; n++) begin
            if (dma_start[n] && !prev_q[n]) dma_cnt[n]++;
        end
        if (src10_cpu_req && !prev_q[4]) cpu10_cnt++;
        if (src11_cpu_req && !prev_q[5]) cpu11_cnt++;
        prev_q <= {src11_cpu_req, src10_cpu_req, dma_start};
    end

    task automatic set_pin(input int which, input logic v);
        @(posedge aclk);
        if (which == 10) ext_irq_pin_five <= v;
        else ext_irq_pin_six <= v;
    endtask
endmodule

// ===== dv/tb_eim_ctrl.sv
// Self-checking bench for the mode control of sources 10 and 11.
// Assumes the far-side model eim_far_end and the register map of eim_pkg.
`timescale 1ns/1ps
module tb_eim_ctrl;
    import eim_pkg::*;
    logic        aclk, aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, dma_start;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        ext_irq_pin_five, ext_irq_pin_six, src10_cpu_req, src11_cpu_req, irq;
    logic [2:0]  src10_cpu_prio, src11_cpu_prio;
    int          bad_count;
    int          checks_done;

    eim_ctrl #(.AW(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_irq_pin_five, .ext_irq_pin_six, .src10_cpu_req, .src10_cpu_prio,
        .src11_cpu_req, .src11_cpu_prio, .dma_start, .irq);
    eim_far_end far (.aclk, .dma_start, .src10_cpu_req, .src11_cpu_req, .ext_irq_pin_five, .ext_irq_pin_six);

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
                return;
            end
        end
        bad_count++;
        complete_run();
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                chk("rdata", ed, s_axi_rdata);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                return;
            end
        end
        bad_count++;
        complete_run();
    endtask

    task automatic t_reset();
        axi_read(MODE_ADDR, 32'h0000_0000, RESP_OKAY);
        axi_read(STAT_ADDR, 32'h0000_0000, RESP_OKAY);
        axi_read(MASK_ADDR, 32'h0000_0000, RESP_OKAY);
        chk("prio", 32'h0, {26'h0, src11_cpu_prio, src10_cpu_prio});
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    task automatic t_regs();
        axi_write(MODE_ADDR, 32'hF7F7_FFFF, RESP_OKAY);
        axi_read(MODE_ADDR, 32'h3737_0000, RESP_OKAY);
        chk("prio", 32'h3F, {26'h0, src11_cpu_prio, src10_cpu_prio});
        axi_write(8'h00, 32'hFFFF_FFFF, RESP_SLVERR);
        axi_read(8'h00, 32'h0000_0000, RESP_SLVERR);
        axi_write(MODE_ADDR, 32'h0000_0000, RESP_OKAY);
    endtask

    // Per sense code: {level after high, level after low, pulses in rise phase, pulses in total}.
    task automatic t_sense();
        logic [3:0] tab[4] = '{4'h5, 4'hB, 4'h1, 4'h3};
        logic       l1;
        int         c0, c11, nr;
        for (int s = 0; s < 4; s++) begin
            axi_write(MODE_ADDR, {10'h000, 2'(s), 1'b0, 3'h5, 16'h0000}, RESP_OKAY);
            tick(6);
            c0  = far.cpu10_cnt;
            c11 = far.cpu11_cnt;
            far.set_pin(10, 1'b1);
            tick(6);
            l1 = src10_cpu_req;
            nr = far.cpu10_cnt - c0;
            far.set_pin(10, 1'b0);
            tick(6);
            chk("src10 level", {30'h0, tab[s][3:2]}, {30'h0, l1, src10_cpu_req});
            chk("src10 rise pulses", {31'h0, tab[s][1]}, 32'(nr));
            chk("src10 pulses", {31'h0, tab[s][0]}, 32'(far.cpu10_cnt - c0));
            chk("src11 quiet", 32'h0, 32'(far.cpu11_cnt - c11));
            chk("src10 prio", 32'h5, {29'h0, src10_cpu_prio});
        end
    endtask

    task automatic t_off();
        int c0;
        axi_write(MODE_ADDR, 32'h0010_0000, RESP_OKAY);
        axi_write(STAT_ADDR, 32'h0000_0003, RESP_OKAY);
        c0 = far.cpu10_cnt;
        far.set_pin(10, 1'b1);
        tick(6);
        chk("disabled req", 32'h0, 32'(far.cpu10_cnt - c0));
        axi_read(STAT_ADDR, 32'h0000_0000, RESP_OKAY);
        // Source 11 high level with priority 2, while source 10 stays disabled.
        axi_write(MODE_ADDR, 32'h1210_0000, RESP_OKAY);
        far.set_pin(11, 1'b1);
        tick(6);
        chk("src11 level req", 32'h1, {31'h0, src11_cpu_req});
        chk("src10 still off", 32'h0, {31'h0, src10_cpu_req});
        chk("src11 prio", 32'h2, {29'h0, src11_cpu_prio});
        far.set_pin(11, 1'b0);
        far.set_pin(10, 1'b0);
    endtask

    task automatic t_dma();
        int d0[4];
        int c0;
        int exp_ch;
        for (int ch = 0; ch < 4; ch++) begin
            // Channel codes stay within 0 to 3 in trigger mode; source 10 takes the mirror channel.
            axi_write(MODE_ADDR, {8'(8'h38 + ch), 8'(8'h3B - ch), 16'h0000}, RESP_OKAY);
            tick(6);
            for (int src = 11; src >= 10; src--) begin
                exp_ch = (src == 11) ? ch : 3 - ch;
                d0 = far.dma_cnt;
                c0 = far.cpu10_cnt + far.cpu11_cnt;
                far.set_pin(src, 1'b1);
                tick(6);
                far.set_pin(src, 1'b0);
                tick(6);
                for (int n = 0; n < 4; n++) begin
                    chk("dma start", (n == exp_ch) ? 32'h1 : 32'h0, 32'(far.dma_cnt[n] - d0[n]));
                end
                chk("cpu in trigger mode", 32'h0, 32'(far.cpu10_cnt + far.cpu11_cnt - c0));
            end
        end
    endtask

    task automatic t_irq();
        axi_write(MODE_ADDR, 32'h3831_0000, RESP_OKAY);
        axi_write(STAT_ADDR, 32'h0000_0003, RESP_OKAY);
        axi_write(MASK_ADDR, 32'h0000_0001, RESP_OKAY);
        axi_read(STAT_ADDR, 32'h0000_0000, RESP_OKAY);
        far.set_pin(11, 1'b1);
        tick(6);
        axi_read(STAT_ADDR, 32'h0000_0002, RESP_OKAY);
        chk("irq masked", 32'h0, {31'h0, irq});
        far.set_pin(10, 1'b1);
        tick(6);
        chk("irq set", 32'h1, {31'h0, irq});
        axi_write(STAT_ADDR, 32'h0000_0001, RESP_OKAY);
        axi_read(STAT_ADDR, 32'h0000_0002, RESP_OKAY);
        chk("irq cleared", 32'h0, {31'h0, irq});
        axi_write(MASK_ADDR, 32'h0000_0003, RESP_OKAY);
        tick(2);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        axi_write(STAT_ADDR, 32'h0000_0002, RESP_OKAY);
        axi_read(STAT_ADDR, 32'h0000_0000, RESP_OKAY);
        chk("irq idle", 32'h0, {31'h0, irq});
        far.set_pin(10, 1'b0);
        far.set_pin(11, 1'b0);
    endtask

    task automatic t_rerun();
        axi_write(MODE_ADDR, 32'h3831_0000, RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        tick(2);
        @(posedge aclk);
        aresetn <= 1'b1;
        tick(1);
        t_reset();
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata  = 32'h0000_0000;
        s_axi_wstrb  = 4'hF;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        tick(1);
        t_reset();
        t_regs();
        t_sense();
        t_off();
        t_dma();
        t_irq();
        t_rerun();
        complete_run();
    end
endmodule
